// ==== rtl/psmc_pkg.sv ====
// Purpose: Shared constants and types of the power source mode controller.
// Assumes: 50 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package psmc_pkg;

    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SWITCH_MAX_NS   = 14_000;
    localparam int unsigned ACT_WINDOW_NS   = 120_000;
    localparam int unsigned QUAL_TIME_MS    = 3_600;
    localparam int unsigned TEMP_LIMIT_C    = 60;
    localparam int unsigned EXT_CUR_MAX_MA  = 850;
    localparam int unsigned POLL_TIME_MS    = 1_000;
    localparam int unsigned CHG_CUR_MA      = 212;

    // Bit positions of the synchronised level inputs
    localparam int unsigned SY_HOST = 0;
    localparam int unsigned SY_EXT  = 1;
    localparam int unsigned SY_USB  = 2;
    localparam int unsigned SY_HDR  = 3;
    localparam int unsigned SY_SW   = 4;
    localparam int unsigned SY_DRAW = 5;
    localparam int unsigned SY_FULL = 6;
    localparam int unsigned SY_HALT = 7;
    localparam int unsigned SY_W    = 8;
    // Host draw idles high after reset
    localparam logic [SY_W-1:0] SY_IDLE = SY_W'(1) << SY_DRAW;

    // Longest time rounds down; at least one cycle
    localparam int unsigned SWITCH_CYC =
        (SWITCH_MAX_NS / 20 > 0) ? SWITCH_MAX_NS / 20 : 1;
    localparam int unsigned QUAL_CYC =
        QUAL_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned POLL_CYC =
        POLL_TIME_MS * (CLK_HZ / 1000);

    localparam int unsigned TIMER_W = 28;
    localparam int unsigned TEMP_W  = 8;
    localparam int unsigned CUR_W   = 12;

    typedef enum logic [2:0] {
        PSMC_USB,
        PSMC_EXT,
        PSMC_BAT,
        PSMC_LPB,
        PSMC_HOST
    } psmc_mode_t;

    typedef enum logic [1:0] {
        PSMC_CHG_OFF,
        PSMC_CHG_NORMAL,
        PSMC_CHG_TRICKLE
    } psmc_chg_t;

endpackage

// ==== rtl/psmc_ctrl.sv ====
// Purpose: Supervisory power source mode controller with charger gating
//          and protective shutdown.
// Assumes: Source-good, over-limit and temperature inputs come from
//          comparators outside this clock domain and are synchronised here.
// Notes:   Battery changeover is immediate, well inside the switch budget.
//
// Contract
// [RL1] Five powering states only
// [RL2] External input wins over micro-USB
// [RL3] Micro-USB loss goes to battery
// [RL4] External loss without micro-USB goes battery
// [RL5] No cable source means battery mode
// [RL6] Battery changeover under 14 us
// [RL7] Return after 3.6 s stable cable
// [RL8] Instability restarts the qualification timer
// [RL9] Over 60 C stops charging
// [RL10] Over 60 C emergency shutdown then power off
// [RL11] Over-current shutdown then power off
// [RL12] External input continuous draw capped 850 mA
// [RL13] Full battery switches to trickle charge
// [RL14] Charge off when supply insufficient
// [RL15] No charging in battery mode
// [RL16] Modes decided from voltages and current
// [RL17] Active mode readable by scripting
// [RL18] Priority host, external, micro-USB, battery
// [RL19] Low-power mode polls cable sources
// [RL20] Leave battery into best present source
`timescale 1ns/10ps
`default_nettype none

module psmc_ctrl
    import psmc_pkg::*;
#(
    parameter int unsigned QUAL_CYCLES = QUAL_CYC,
    parameter int unsigned POLL_CYCLES = POLL_CYC,
    parameter int unsigned SD_CYCLES   = 5000
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             host_src_ok_i,
    input  wire logic             ext_src_ok_i,
    input  wire logic             usb_src_ok_i,
    input  wire logic             header_ok_i,
    input  wire logic             switch_on_i,
    input  wire logic             host_draw_i,
    input  wire logic [TEMP_W-1:0] temp_c_i,
    input  wire logic [CUR_W-1:0] cur_ma_i,
    input  wire logic [CUR_W-1:0] cur_limit_ma_i,
    input  wire logic [CUR_W-1:0] chg_headroom_ma_i,
    input  wire logic             batt_full_i,
    input  wire logic             host_halted_i,
    output psmc_pkg::psmc_mode_t  mode_o,
    output logic                  use_host_o,
    output logic                  use_ext_o,
    output logic                  use_usb_o,
    output logic                  use_batt_o,
    output psmc_pkg::psmc_chg_t   chg_o,
    output logic                  shutdown_req_o,
    output logic                  power_en_o
);
    import psmc_pkg::*;

    localparam logic [CUR_W-1:0] EXT_MAX = CUR_W'(EXT_CUR_MAX_MA);
    localparam logic [TEMP_W-1:0] TMAX  = TEMP_W'(TEMP_LIMIT_C);
    localparam logic [CUR_W-1:0] CHG_MA = CUR_W'(CHG_CUR_MA);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers (level signals, two stages each)
    // Only the second stage is read; the first may still be settling.
    localparam int unsigned NS = SY_W;
    logic [NS-1:0]     lvl_in;
    logic [NS-1:0]     s1_q;
    logic [NS-1:0]     s2_q;
    logic [TEMP_W-1:0] t1_q;
    logic [TEMP_W-1:0] t2_q;
    logic [CUR_W-1:0]  c1_q;
    logic [CUR_W-1:0]  c2_q;

    assign lvl_in[SY_HOST] = host_src_ok_i;
    assign lvl_in[SY_EXT]  = ext_src_ok_i;
    assign lvl_in[SY_USB]  = usb_src_ok_i;
    assign lvl_in[SY_HDR]  = header_ok_i;
    assign lvl_in[SY_SW]   = switch_on_i;
    assign lvl_in[SY_DRAW] = host_draw_i;
    assign lvl_in[SY_FULL] = batt_full_i;
    assign lvl_in[SY_HALT] = host_halted_i;

    // Host draw resets high: a zero here would read as an idle host and
    // send the machine into low-power mode before the first real sample.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= SY_IDLE;
            s2_q <= SY_IDLE;
        end else begin
            s1_q <= lvl_in;
            s2_q <= s1_q;
        end
    end

    // Readings are assumed slow next to the clock; a sample taken
    // mid-change is off by one step for a single cycle at most.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            t1_q <= '0;
            t2_q <= '0;
        end else begin
            t1_q <= temp_c_i;
            t2_q <= t1_q;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            c1_q <= '0;
            c2_q <= '0;
        end else begin
            c1_q <= cur_ma_i;
            c2_q <= c1_q;
        end
    end

    logic host_ok;
    logic ext_ok;
    logic usb_ok;
    logic hdr_ok;
    logic sw_on;
    logic drawing;
    logic full;
    logic halted;
    assign host_ok = s2_q[SY_HOST];
    assign ext_ok  = s2_q[SY_EXT];
    assign usb_ok  = s2_q[SY_USB];
    assign hdr_ok  = s2_q[SY_HDR];
    assign sw_on   = s2_q[SY_SW];
    assign drawing = s2_q[SY_DRAW];
    assign full    = s2_q[SY_FULL];
    assign halted  = s2_q[SY_HALT];

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    // Fixed priority: host socket, external input, micro-USB
    function automatic psmc_mode_t best_src(input logic h, input logic e,
                                            input logic u);
        psmc_mode_t m;
        m = PSMC_BAT;
        if (h) begin
            m = PSMC_HOST; // RL18
        end else if (e) begin
            m = PSMC_EXT; // RL2
        end else if (u) begin
            m = PSMC_USB;
        end
        return m;
    endfunction

    logic any_src;
    assign any_src = host_ok | ext_ok | usb_ok;

    psmc_mode_t mode_q;
    logic [TIMER_W-1:0] qual_q;
    logic [TIMER_W-1:0] poll_q;
    logic qualified;
    assign qualified = (qual_q >= TIMER_W'(QUAL_CYCLES - 1)) & any_src;

    // Any change of the source set, or no source present, restarts qualification
    logic [2:0] src_vec_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            qual_q    <= '0;
            src_vec_q <= '0;
        end else begin
            src_vec_q <= {host_ok, ext_ok, usb_ok};
            if (!any_src || src_vec_q != {host_ok, ext_ok, usb_ok}) begin
                qual_q <= '0; // RL8
            end else if (!qualified) begin
                qual_q <= qual_q + 1'b1; // RL7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protection
    logic over_temp;
    logic over_cur;
    logic fault_q;
    logic [TIMER_W-1:0] sd_q;
    logic pwr_q;
    // A fault latches until reset: a cooling board must not restart
    // a host that was already told to halt.
    assign over_temp = t2_q > TMAX; // RL9
    assign over_cur = (c2_q > cur_limit_ma_i) |
                      ((mode_q == PSMC_EXT) & (c2_q > EXT_MAX)); // RL12

    // After a fault, power is cut once host reports halt or the shutdown grace expires
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
            sd_q    <= '0;
            pwr_q   <= 1'b1;
        end else begin
            if (over_temp | over_cur) begin
                fault_q <= 1'b1; // RL10 RL11
            end
            if (fault_q && pwr_q) begin
                sd_q <= sd_q + 1'b1;
                if (halted || sd_q >= TIMER_W'(SD_CYCLES - 1)) begin
                    pwr_q <= 1'b0; // RL10 RL11
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode state machine
    // Falling back to battery never waits: the cable side is gone and
    // the hold-up capacitor only bridges a few microseconds. Going back
    // to cable always waits for a full qualification, so a sagging
    // supply cannot make the machine toggle between sources.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= PSMC_BAT;
            poll_q <= '0;
        end else begin
            poll_q <= '0;
            unique case (mode_q) // RL1 RL16
                PSMC_USB: begin
                    // Same-cycle fallback keeps changeover in one clock
                    if (!usb_ok || !hdr_ok || host_ok || ext_ok) begin
                        mode_q <= (host_ok || ext_ok) ?
                                  best_src(host_ok, ext_ok, 1'b0) :
                                  PSMC_BAT; // RL3 RL6
                    end
                end
                PSMC_EXT: begin
                    if (host_ok) begin
                        mode_q <= PSMC_HOST;
                    end else if (!ext_ok || !hdr_ok) begin
                        mode_q <= PSMC_BAT; // RL4 RL6
                    end
                end
                PSMC_HOST: begin
                    if (!host_ok || !hdr_ok) begin
                        mode_q <= PSMC_BAT; // RL5 RL6
                    end
                end
                PSMC_BAT: begin
                    if (qualified && hdr_ok) begin
                        mode_q <= best_src(host_ok, ext_ok, usb_ok); // RL20
                    end else if (!any_src && !drawing) begin
                        mode_q <= PSMC_LPB;
                    end
                end
                PSMC_LPB: begin
                    poll_q <= poll_q + 1'b1;
                    if (poll_q >= TIMER_W'(POLL_CYCLES - 1)) begin
                        poll_q <= '0;
                        if (qualified) begin
                            mode_q <= best_src(host_ok, ext_ok,
                                               usb_ok); // RL19
                        end else if (drawing) begin
                            mode_q <= PSMC_BAT; // RL19
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Charger
    // Protection and battery mode come first so that no later branch
    // can turn the charger back on while either holds.
    psmc_chg_t chg_q;
    logic cable;
    assign cable = (mode_q != PSMC_BAT) && (mode_q != PSMC_LPB);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chg_q <= PSMC_CHG_OFF;
        end else if (!cable || fault_q) begin
            chg_q <= PSMC_CHG_OFF; // RL15
        end else if (over_temp) begin
            chg_q <= PSMC_CHG_OFF; // RL9
        end else if (chg_headroom_ma_i < CHG_MA) begin
            chg_q <= PSMC_CHG_OFF; // RL14
        end else if (full) begin
            chg_q <= PSMC_CHG_TRICKLE; // RL13
        end else begin
            chg_q <= PSMC_CHG_NORMAL; // RL14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Source switches follow the mode one cycle late; break-before-make
    // timing of the analog switches is left to the switch drivers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            use_host_o <= 1'b0;
        end else begin
            use_host_o <= pwr_q && mode_q == PSMC_HOST; // RL18
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            use_ext_o <= 1'b0;
        end else begin
            use_ext_o <= pwr_q && mode_q == PSMC_EXT;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            use_usb_o <= 1'b0;
        end else begin
            use_usb_o <= pwr_q && mode_q == PSMC_USB; // RL2
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            use_batt_o <= 1'b0;
        end else begin
            use_batt_o <= pwr_q && !cable; // RL5
        end
    end

    assign mode_o         = mode_q; // RL17
    assign chg_o          = chg_q;
    assign shutdown_req_o = fault_q;
    assign power_en_o     = pwr_q;

endmodule

`default_nettype wire

// ==== sim/psmc_ctrl_checker.sv ====
// Purpose: Port-level checks of the power source mode controller
// Assumes: QUAL_CYCLES matches the instance under check
// Notes:   Source stability is counted on raw inputs, ahead of the syncs
`timescale 1ns/10ps
`default_nettype none
module psmc_ctrl_checker
    import psmc_pkg::*;
#(
    parameter int unsigned QUAL_CYCLES = 20
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             host_src_ok_i,
    input wire logic             ext_src_ok_i,
    input wire logic             usb_src_ok_i,
    input wire logic [TEMP_W-1:0] temp_c_i,
    input wire logic [CUR_W-1:0] cur_ma_i,
    input wire psmc_mode_t       mode_o,
    input wire logic             use_host_o,
    input wire logic             use_ext_o,
    input wire logic             use_usb_o,
    input wire logic             use_batt_o,
    input wire psmc_chg_t        chg_o,
    input wire logic             shutdown_req_o,
    input wire logic             power_en_o
);
    import psmc_pkg::*;
    logic [2:0] src_q;
    logic [7:0] stab_q;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_q  <= 3'h0;
            stab_q <= 8'h00;
        end else begin
            src_q  <= {host_src_ok_i, ext_src_ok_i, usb_src_ok_i};
            // Saturate so a long calm spell never wraps back to zero
            if ({host_src_ok_i, ext_src_ok_i, usb_src_ok_i} != src_q)
                stab_q <= 8'h00;
            else if (stab_q != 8'hFF)
                stab_q <= stab_q + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_no_cable_bat: assert property (
        (!usb_src_ok_i && !ext_src_ok_i && !host_src_ok_i)[*4] |->
        mode_o inside {PSMC_BAT, PSMC_LPB}) else $error("cable mode kept");
    chk_bat_switch: assert property ((mode_o == PSMC_BAT && power_en_o)[*2]
        |=> use_batt_o && !use_usb_o && !use_ext_o) else $error("no battery");
    chk_bat_no_chg: assert property (mode_o == PSMC_BAT [*2] |=>
        chg_o == PSMC_CHG_OFF) else $error("charging on battery");
    chk_ext_over_usb: assert property ((ext_src_ok_i && usb_src_ok_i)[*5]
        |-> !use_usb_o) else $error("usb powers beside ext");
    chk_host_first: assert property (host_src_ok_i [*5] |->
        !use_ext_o && !use_usb_o) else $error("host source not first");
    chk_qual_time: assert property (
        $past(mode_o) inside {PSMC_BAT, PSMC_LPB} &&
        !(mode_o inside {PSMC_BAT, PSMC_LPB}) |-> stab_q >= QUAL_CYCLES)
        else $error("left battery early");
    chk_temp_shut: assert property ((temp_c_i > TEMP_LIMIT_C)[*4] |->
        ##[1:2] (shutdown_req_o && chg_o == PSMC_CHG_OFF))
        else $error("no over temp shutdown");
    chk_ext_cur_cap: assert property (
        (mode_o == PSMC_EXT && cur_ma_i > EXT_CUR_MAX_MA)[*4] |=>
        shutdown_req_o) else $error("ext current not capped");
    chk_power_order: assert property (!power_en_o |-> shutdown_req_o
        ##1 !power_en_o) else $error("power cut unordered");
    cov_back_usb: cover property ($past(mode_o) == PSMC_BAT &&
        mode_o == PSMC_USB);
    cov_low_power: cover property (mode_o == PSMC_LPB);
    cov_power_cut: cover property ($fell(power_en_o));
endmodule
bind psmc_ctrl psmc_ctrl_checker #(.QUAL_CYCLES(QUAL_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== sim/psmc_host_model.sv ====
// Purpose: Host board and cable source stand-in
// Assumes: Cable levels are commanded by the bench
// Notes:   Host ends its orderly halt two cycles after the request
`timescale 1ns/10ps
`default_nettype none
module psmc_host_model (
    input  wire logic       clk_i,
    input  wire logic [2:0] cab_i,
    input  wire logic       shut_i,
    input  wire logic       use_any_i,
    output logic            host_ok_o,
    output logic            ext_ok_o,
    output logic            usb_ok_o,
    output logic            header_ok_o,
    output logic            halted_o
);
    logic [1:0] halt_q = 2'h0;
    assign {host_ok_o, ext_ok_o, usb_ok_o} = cab_i;
    assign header_ok_o = use_any_i;
    always_ff @(negedge clk_i) begin
        halt_q <= {halt_q[0], shut_i};
    end
    assign halted_o = halt_q[1];
endmodule
`default_nettype wire

// ==== sim/psmc_ctrl_tb.sv ====
// Purpose: Scenario bench of the power source mode controller
// Assumes: Shortened qualification and poll counts
// Notes:   Each scenario starts from a fresh reset
`timescale 1ns/10ps
`default_nettype none
module psmc_ctrl_tb;
    import psmc_pkg::*;
    logic clk_i, rst_i, draw, full, ho, eo, uo, hdr, hlt, shut, pen;
    logic uh, ue, uu, ub;
    logic [2:0] cab;
    logic [7:0] temp;
    logic [11:0] cur, room;
    psmc_mode_t mode;
    psmc_chg_t chg;
    int fails, tests_run;
    psmc_ctrl #(.QUAL_CYCLES(20), .POLL_CYCLES(8), .SD_CYCLES(10)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .host_src_ok_i(ho),
        .ext_src_ok_i(eo), .usb_src_ok_i(uo), .header_ok_i(hdr),
        .switch_on_i(1'b1), .host_draw_i(draw), .temp_c_i(temp),
        .cur_ma_i(cur), .cur_limit_ma_i(12'h7D0), .chg_headroom_ma_i(room),
        .batt_full_i(full), .host_halted_i(hlt), .mode_o(mode),
        .use_host_o(uh), .use_ext_o(ue), .use_usb_o(uu), .use_batt_o(ub),
        .chg_o(chg), .shutdown_req_o(shut), .power_en_o(pen));
    psmc_host_model u_host (.clk_i(clk_i), .cab_i(cab), .shut_i(shut),
        .use_any_i(uh | ue | uu | ub), .host_ok_o(ho), .ext_ok_o(eo),
        .usb_ok_o(uo), .header_ok_o(hdr), .halted_o(hlt));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic go(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic wait_mode(input psmc_mode_t m, input int n);
        for (int k = 0; k < n && mode !== m; k++) @(negedge clk_i);
        chk("mode", m, mode);
    endtask
    task automatic start(input logic [2:0] c);
        rst_i = 1'b1; cab = 3'h0; temp = 8'h19; cur = 12'h064;
        room = 12'h12C; full = 1'b0; draw = 1'b1;
        go(8);
        rst_i = 1'b0;
        cab = c;
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_usb_loss;
        start(3'h1);
        go(10);
        chk("mode", PSMC_BAT, mode);
        wait_mode(PSMC_USB, 40);
        cab = 3'h0;
        wait_mode(PSMC_BAT, 4);
        go(1);
        chk("use_batt", 8'h01, ub);
        chk("chg", PSMC_CHG_OFF, chg);
    endtask
    task automatic t_ext_prio;
        start(3'h3);
        wait_mode(PSMC_EXT, 40);
        chk("use_usb", 8'h00, uu);
        cab = 3'h0;
        wait_mode(PSMC_BAT, 4);
    endtask
    task automatic t_requal;
        start(3'h1);
        go(12);
        cab = 3'h0;
        go(1);
        cab = 3'h1;
        go(15);
        chk("mode", PSMC_BAT, mode);
        wait_mode(PSMC_USB, 20);
    endtask
    task automatic t_host_prio;
        start(3'h7);
        wait_mode(PSMC_HOST, 40);
        go(1);
        chk("use_host", 8'h01, uh);
        chk("use_ext", 8'h00, ue);
    endtask
    task automatic t_charge;
        start(3'h1);
        wait_mode(PSMC_USB, 40);
        go(5);
        chk("chg", PSMC_CHG_NORMAL, chg);
        full = 1'b1;
        go(5);
        chk("chg", PSMC_CHG_TRICKLE, chg);
        room = 12'h064;
        go(5);
        chk("chg", PSMC_CHG_OFF, chg);
        room = 12'h12C;
        go(5);
        chk("chg", PSMC_CHG_TRICKLE, chg);
    endtask
    task automatic t_low_power;
        start(3'h0);
        draw = 1'b0;
        go(6);
        chk("mode", PSMC_LPB, mode);
        cab = 3'h2;
        wait_mode(PSMC_EXT, 60);
    endtask
    task automatic t_fault(input logic hot);
        start(hot ? 3'h1 : 3'h2);
        wait_mode(hot ? PSMC_USB : PSMC_EXT, 40);
        if (hot) temp = 8'h3C;
        else cur = 12'h352;
        go(6);
        chk("shutdown", 8'h00, shut);
        if (hot) temp = 8'h3D;
        else cur = 12'h384;
        go(5);
        chk("shutdown", 8'h01, shut);
        chk("chg", PSMC_CHG_OFF, chg);
        go(14);
        chk("power_en", 8'h00, pen);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        fails++;
        stop_test();
    end
    initial begin
        fails = 0;
        tests_run = 0;
        t_usb_loss();
        t_ext_prio();
        t_requal();
        t_host_prio();
        t_charge();
        t_low_power();
        t_fault(1'b1);
        t_fault(1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
